// ==== rtl/swcfg_pkg.sv ====
// swcfg_pkg: register map, field layout and reset values for the system
// configuration bank (master weights, software interrupt, software reset).
// assumes a plain address/strobe register port with 32-bit data.
package swcfg_pkg;
   // register byte offsets
   localparam logic [7:0] SWCFG_OFF_WEIGHT = 8'h00;
   localparam logic [7:0] SWCFG_OFF_IRQ = 8'h04;
   localparam logic [7:0] SWCFG_OFF_RESET = 8'h08;
   // weight fields
   localparam int SWCFG_GFX_LSB = 10;
   localparam int SWCFG_DMA_LSB = 0;
   localparam int SWCFG_WFLD_W = 5;
   localparam int SWCFG_WDEC_W = 6;
   localparam logic [5:0] SWCFG_WEIGHT_MAX = 6'h20;
   localparam logic [4:0] SWCFG_WFLD_RST = 5'h00;
   // interrupt bit
   localparam int SWCFG_IRQ_BIT = 0;
   // reset control bits
   localparam int SWCFG_RST_DDRFIC = 26;
   localparam int SWCFG_RST_DDRCTL = 25;
   localparam int SWCFG_RST_FIF1 = 19;
   localparam int SWCFG_RST_FIF0 = 18;
   localparam int SWCFG_RST_FDMA = 17;
   localparam int SWCFG_RST_FABRIC = 16;
   localparam int SWCFG_RST_COMM = 15;
   localparam int SWCFG_RST_SPI = 9;
   localparam int SWCFG_RST_PERIPH_DMA_ENGINE = 5;
   localparam int SWCFG_RST_SRAM1 = 3;
   localparam int SWCFG_RST_SRAM0 = 2;
   localparam int SWCFG_RST_NVM1 = 1;
   localparam int SWCFG_RST_NVM0 = 0;
   // writable bits and default values
   localparam logic [31:0] SWCFG_WEIGHT_MASK = 32'h00007c1f;
   localparam logic [31:0] SWCFG_IRQ_MASK = 32'h00000001;
   localparam logic [31:0] SWCFG_RESET_MASK = 32'h060f822f;
   localparam logic [31:0] SWCFG_RESET_DFLT = 32'h060f0220;
   localparam logic [31:0] SWCFG_ZERO = 32'h00000000;

   // decoded weights handed to the arbiter
   typedef struct packed {
      logic [5:0] gfx;
      logic [5:0] fdma;
   } swcfg_weights_t;

   // per-block reset holds
   typedef struct packed {
      logic ddr_fabric_if_reset;
      logic ddr_controller_reset;
      logic fabric_if1_reset;
      logic fabric_if0_reset;
      logic fast_dma_reset;
      logic fabric_logic_reset;
      logic comm_block_reset;
      logic serial_periph_reset;
      logic periph_dma_reset;
      logic sram1_ctrl_reset;
      logic sram0_ctrl_reset;
      logic nvm1_ctrl_reset;
      logic nvm0_ctrl_reset;
   } swcfg_resets_t;
endpackage

// ==== rtl/swcfg_regs.sv ====
// swcfg_regs: software-written configuration bank driving arbiter weights,
// a fabric software interrupt line and per-block reset holds.
// assumes one 125 MHz clock and a master that never issues both strobes.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01: graphics master weight field sits at bits 14:10, decoded to the arbiter.
// RULE_02: fast DMA master weight field sits at bits 4:0, decoded to the arbiter.
// RULE_03: field value zero means weight 32; values 1 to 31 mean themselves.
// RULE_04: both weight fields reset to zero, giving weight 32 after reset.
// RULE_05: interrupt register bit 0 drives the fabric software interrupt; resets low.
// RULE_06: bit 26 holds the DDR fabric interface in reset; default one.
// RULE_07: bit 25 holds the DDR memory controller in reset; default one.
// RULE_08: bits 19 and 18 hold fabric interfaces one and zero; default one.
// RULE_09: bit 17 holds the fast DMA engine in reset; default one.
// RULE_10: bit 16 holds the fabric logic in reset; default one.
// RULE_11: bit 15 holds the communication block in reset; default zero.
// RULE_12: bit 9 holds the serial peripheral block in reset; default one.
// RULE_13: bit 5 holds the peripheral DMA engine in reset; default one.
// RULE_14: bits 3 and 2 hold SRAM controllers one and zero; default zero.
// RULE_15: bits 1 and 0 hold NVM controllers one and zero; default zero.
// RULE_16: a block enabled by configuration gets reset default zero instead.
// RULE_17: on small variants software sets these fields only statically.
// RULE_18: reserved bits read zero and ignore writes.
module swcfg_regs
   import swcfg_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [31:0] periph_enabled_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [31:0] reg_rdata_out,
   output logic reg_err_out,
   output swcfg_weights_t weights_out,
   output logic fabric_irq_interface_out,
   output swcfg_resets_t resets_out
);

   // ----------------------------------------------------------------
   // registers and decode
   // ----------------------------------------------------------------
   logic [31:0] weight_q;
   logic [31:0] irq_q;
   logic [31:0] reset_q;
   logic [31:0] rdata_q;
   logic err_q;
   logic reset_loaded_q;
   logic [31:0] reset_dflt;

   wire sel_weight = (reg_addr_in == SWCFG_OFF_WEIGHT);
   wire sel_irq = (reg_addr_in == SWCFG_OFF_IRQ);
   wire sel_reset = (reg_addr_in == SWCFG_OFF_RESET);
   wire sel_any = sel_weight | sel_irq | sel_reset;

   // enabled blocks default to released
   assign reset_dflt = SWCFG_RESET_DFLT & ~periph_enabled_in; // RULE_16

   // read mux; unmapped address reads zero
   wire [31:0] rmux = sel_weight ? weight_q :
                      sel_irq ? irq_q :
                      sel_reset ? reset_q : SWCFG_ZERO;

   // ----------------------------------------------------------------
   // weight and interrupt registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         weight_q <= SWCFG_ZERO; // RULE_04
         irq_q <= SWCFG_ZERO; // RULE_05
      end else if (reg_write_in) begin
         if (sel_weight) weight_q <= reg_wdata_in & SWCFG_WEIGHT_MASK; // RULE_18
         if (sel_irq) irq_q <= reg_wdata_in & SWCFG_IRQ_MASK; // RULE_18
      end
   end

   // ----------------------------------------------------------------
   // reset control: fixed default word loaded under reset, configured default caught
   // on the first clock after release, then software owns it
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reset_q <= SWCFG_RESET_DFLT;
         reset_loaded_q <= 1'b0;
      end else if (!reset_loaded_q) begin
         reset_q <= reset_dflt; // RULE_16
         reset_loaded_q <= 1'b1;
      end else if (reg_write_in && sel_reset) begin
         reset_q <= reg_wdata_in & SWCFG_RESET_MASK; // RULE_18
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= SWCFG_ZERO;
         err_q <= 1'b0;
      end else begin
         rdata_q <= reg_read_in ? rmux : SWCFG_ZERO;
         err_q <= (reg_read_in | reg_write_in) & ~sel_any;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign reg_err_out = err_q;

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   function automatic logic [5:0] wdec(input logic [4:0] f);
      wdec = (f == SWCFG_WFLD_RST) ? SWCFG_WEIGHT_MAX : {1'b0, f}; // RULE_03
   endfunction

   wire [4:0] gfx_fld = weight_q[SWCFG_GFX_LSB +: SWCFG_WFLD_W]; // RULE_01
   wire [4:0] dma_fld = weight_q[SWCFG_DMA_LSB +: SWCFG_WFLD_W]; // RULE_02
   assign weights_out.gfx = wdec(gfx_fld); // RULE_01
   assign weights_out.fdma = wdec(dma_fld); // RULE_02
   assign fabric_irq_interface_out = irq_q[SWCFG_IRQ_BIT]; // RULE_05

   // reset holds; fields are used as loaded (static use on small parts)
   assign resets_out.ddr_fabric_if_reset = reset_q[SWCFG_RST_DDRFIC]; // RULE_06
   assign resets_out.ddr_controller_reset = reset_q[SWCFG_RST_DDRCTL]; // RULE_07
   assign resets_out.fabric_if1_reset = reset_q[SWCFG_RST_FIF1]; // RULE_08
   assign resets_out.fabric_if0_reset = reset_q[SWCFG_RST_FIF0]; // RULE_08
   assign resets_out.fast_dma_reset = reset_q[SWCFG_RST_FDMA]; // RULE_09
   assign resets_out.fabric_logic_reset = reset_q[SWCFG_RST_FABRIC]; // RULE_10
   assign resets_out.comm_block_reset = reset_q[SWCFG_RST_COMM]; // RULE_11
   assign resets_out.serial_periph_reset = reset_q[SWCFG_RST_SPI]; // RULE_12
   assign resets_out.periph_dma_reset = reset_q[SWCFG_RST_PERIPH_DMA_ENGINE]; // RULE_13
   assign resets_out.sram1_ctrl_reset = reset_q[SWCFG_RST_SRAM1]; // RULE_14
   assign resets_out.sram0_ctrl_reset = reset_q[SWCFG_RST_SRAM0]; // RULE_14
   assign resets_out.nvm1_ctrl_reset = reset_q[SWCFG_RST_NVM1]; // RULE_15
   assign resets_out.nvm0_ctrl_reset = reset_q[SWCFG_RST_NVM0]; // RULE_15

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_wr(logic [7:0] off);
      reg_write_in && reg_addr_in == off;
   endsequence

   sequence s_rd(logic [7:0] off);
      reg_read_in && reg_addr_in == off;
   endsequence

   // a reset register write once the configured default has been caught
   sequence s_wr_loaded;
      reset_loaded_q and s_wr(SWCFG_OFF_RESET);
   endsequence

   property p_gfx_weight;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr(SWCFG_OFF_WEIGHT) |=> weights_out.gfx ==
         (($past(reg_wdata_in[14:10]) == 5'h00) ? 6'h20 : {1'b0, $past(reg_wdata_in[14:10])});
   endproperty
   a_gfx_weight: assert property (p_gfx_weight) else $error("graphics weight wrong"); // RULE_01

   property p_dma_weight;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr(SWCFG_OFF_WEIGHT) |=> weights_out.fdma ==
         (($past(reg_wdata_in[4:0]) == 5'h00) ? 6'h20 : {1'b0, $past(reg_wdata_in[4:0])});
   endproperty
   a_dma_weight: assert property (p_dma_weight) else $error("dma weight wrong"); // RULE_02

   property p_weight_range;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      weights_out.gfx != 6'h00 && weights_out.gfx <= 6'h20 && weights_out.fdma != 6'h00;
   endproperty
   a_weight_range: assert property (p_weight_range) else $error("weight out of range"); // RULE_03

   property p_weight_reset;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(reset_loaded_q) |-> weights_out.gfx == 6'h20 && weights_out.fdma == 6'h20;
   endproperty
   a_weight_reset: assert property (p_weight_reset) else $error("weight not 32 after reset"); // RULE_04

   property p_irq;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr(SWCFG_OFF_IRQ) |=> fabric_irq_interface_out == $past(reg_wdata_in[0]);
   endproperty
   a_irq: assert property (p_irq) else $error("software irq mismatch"); // RULE_05

   property p_irq_hold;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !(reg_write_in && sel_irq) |=> $stable(fabric_irq_interface_out);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq changed without write"); // RULE_05

   property p_rst_default;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(reset_loaded_q) |-> resets_out.ddr_fabric_if_reset == !$past(periph_enabled_in[26])
         && resets_out.comm_block_reset == 1'b0 && resets_out.nvm0_ctrl_reset == 1'b0
         && resets_out.serial_periph_reset == !$past(periph_enabled_in[9]);
   endproperty
   a_rst_default: assert property (p_rst_default) else $error("reset default wrong"); // RULE_16

   property p_rst_write;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr_loaded |=>
         resets_out.fast_dma_reset == $past(reg_wdata_in[17])
         && resets_out.fabric_logic_reset == $past(reg_wdata_in[16])
         && resets_out.ddr_controller_reset == $past(reg_wdata_in[25]);
   endproperty
   a_rst_write: assert property (p_rst_write) else $error("reset write not applied"); // RULE_09

   property p_reserved;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      reg_read_in |=> (reg_rdata_out & ~(SWCFG_WEIGHT_MASK | SWCFG_RESET_MASK)) == 32'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // RULE_18

   // ----------------------------------------------------------------
   // checks on stored state and the register port
   // ----------------------------------------------------------------
   property p_dma_max;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      weights_out.fdma <= SWCFG_WEIGHT_MAX;
   endproperty
   a_dma_max: assert property (p_dma_max) else $error("dma weight above 32"); // RULE_03

   property p_weight_rsvd;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (weight_q & ~SWCFG_WEIGHT_MASK) == SWCFG_ZERO;
   endproperty
   a_weight_rsvd: assert property (p_weight_rsvd) else $error("weight reserved bit set"); // RULE_18

   property p_irq_rsvd;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (irq_q & ~SWCFG_IRQ_MASK) == SWCFG_ZERO;
   endproperty
   a_irq_rsvd: assert property (p_irq_rsvd) else $error("irq reserved bit set"); // RULE_18

   property p_reset_rsvd;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (reset_q & ~SWCFG_RESET_MASK) == SWCFG_ZERO;
   endproperty
   a_reset_rsvd: assert property (p_reset_rsvd) else $error("reset reserved bit set"); // RULE_18

   property p_rd_irq;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_rd(SWCFG_OFF_IRQ) |=> reg_rdata_out == {31'h0, $past(fabric_irq_interface_out)};
   endproperty
   a_rd_irq: assert property (p_rd_irq) else $error("irq readback wrong"); // RULE_05

   property p_rd_reset;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_rd(SWCFG_OFF_RESET) |=>
         reg_rdata_out[SWCFG_RST_DDRFIC] == $past(resets_out.ddr_fabric_if_reset)
         && reg_rdata_out[SWCFG_RST_NVM0] == $past(resets_out.nvm0_ctrl_reset);
   endproperty
   a_rd_reset: assert property (p_rd_reset) else $error("reset readback wrong"); // RULE_06

   // read data stand only in the cycle after a read strobe
   property p_rd_idle;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !reg_read_in |=> reg_rdata_out == SWCFG_ZERO;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read"); // RULE_18

   property p_err_set;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (reg_read_in || reg_write_in) && !sel_any |=> reg_err_out;
   endproperty
   a_err_set: assert property (p_err_set) else $error("unmapped access not flagged"); // RULE_18

   property p_err_clr;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !((reg_read_in || reg_write_in) && !sel_any) |=> !reg_err_out;
   endproperty
   a_err_clr: assert property (p_err_clr) else $error("error flag without cause"); // RULE_18

   property p_unmapped_wr;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      reset_loaded_q && reg_write_in && !sel_any |=>
         $stable(weight_q) && $stable(irq_q) && $stable(reset_q);
   endproperty
   a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write changed state"); // RULE_18

   property p_rst_hold;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      reset_loaded_q && !(reg_write_in && sel_reset) |=> $stable(reset_q);
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("reset word changed without write"); // RULE_16

   // ----------------------------------------------------------------
   // checks on each reset hold, written and defaulted
   // ----------------------------------------------------------------
   property p_rst_write_ddr;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr_loaded |=>
         resets_out.ddr_fabric_if_reset == $past(reg_wdata_in[SWCFG_RST_DDRFIC]);
   endproperty
   a_rst_write_ddr: assert property (p_rst_write_ddr) else $error("ddr fabric hold wrong"); // RULE_06

   property p_rst_write_fif;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr_loaded |=>
         resets_out.fabric_if1_reset == $past(reg_wdata_in[SWCFG_RST_FIF1])
         && resets_out.fabric_if0_reset == $past(reg_wdata_in[SWCFG_RST_FIF0]);
   endproperty
   a_rst_write_fif: assert property (p_rst_write_fif) else $error("fabric if hold wrong"); // RULE_08

   property p_rst_write_comm;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr_loaded |=> resets_out.comm_block_reset == $past(reg_wdata_in[SWCFG_RST_COMM]);
   endproperty
   a_rst_write_comm: assert property (p_rst_write_comm) else $error("comm hold wrong"); // RULE_11

   property p_rst_write_spi;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr_loaded |=> resets_out.serial_periph_reset == $past(reg_wdata_in[SWCFG_RST_SPI]);
   endproperty
   a_rst_write_spi: assert property (p_rst_write_spi) else $error("serial hold wrong"); // RULE_12

   property p_rst_write_periph_dma_engine;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr_loaded |=> resets_out.periph_dma_reset == $past(reg_wdata_in[SWCFG_RST_PERIPH_DMA_ENGINE]);
   endproperty
   a_rst_write_periph_dma_engine: assert property (p_rst_write_periph_dma_engine) else $error("periph_dma_engine hold wrong"); // RULE_13

   property p_rst_write_mem;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr_loaded |=>
         resets_out.sram1_ctrl_reset == $past(reg_wdata_in[SWCFG_RST_SRAM1])
         && resets_out.sram0_ctrl_reset == $past(reg_wdata_in[SWCFG_RST_SRAM0]);
   endproperty
   a_rst_write_mem: assert property (p_rst_write_mem) else $error("sram hold wrong"); // RULE_14

   property p_rst_write_nvm;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_wr_loaded |=>
         resets_out.nvm1_ctrl_reset == $past(reg_wdata_in[SWCFG_RST_NVM1])
         && resets_out.nvm0_ctrl_reset == $past(reg_wdata_in[SWCFG_RST_NVM0]);
   endproperty
   a_rst_write_nvm: assert property (p_rst_write_nvm) else $error("nvm hold wrong"); // RULE_15

   property p_dflt_fif;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(reset_loaded_q) |->
         resets_out.fabric_if1_reset == !$past(periph_enabled_in[SWCFG_RST_FIF1])
         && resets_out.fabric_if0_reset == !$past(periph_enabled_in[SWCFG_RST_FIF0]);
   endproperty
   a_dflt_fif: assert property (p_dflt_fif) else $error("fabric if default wrong"); // RULE_08

   property p_dflt_ddrctl;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(reset_loaded_q) |->
         resets_out.ddr_controller_reset == !$past(periph_enabled_in[SWCFG_RST_DDRCTL]);
   endproperty
   a_dflt_ddrctl: assert property (p_dflt_ddrctl) else $error("ddr ctrl default wrong"); // RULE_07

   property p_dflt_fabric;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(reset_loaded_q) |->
         resets_out.fast_dma_reset == !$past(periph_enabled_in[SWCFG_RST_FDMA])
         && resets_out.fabric_logic_reset == !$past(periph_enabled_in[SWCFG_RST_FABRIC]);
   endproperty
   a_dflt_fabric: assert property (p_dflt_fabric) else $error("fabric default wrong"); // RULE_10

   property p_dflt_periph_dma_engine;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(reset_loaded_q) |->
         resets_out.periph_dma_reset == !$past(periph_enabled_in[SWCFG_RST_PERIPH_DMA_ENGINE]);
   endproperty
   a_dflt_periph_dma_engine: assert property (p_dflt_periph_dma_engine) else $error("periph_dma_engine default wrong"); // RULE_13

   property p_dflt_zero;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(reset_loaded_q) |->
         !resets_out.sram1_ctrl_reset && !resets_out.sram0_ctrl_reset
         && !resets_out.nvm1_ctrl_reset;
   endproperty
   a_dflt_zero: assert property (p_dflt_zero) else $error("memory default not zero"); // RULE_14

endmodule // swcfg_regs

`default_nettype wire

// ==== testbench/swcfg_regs_tb_top.sv ====
// swcfg_regs_tb_top: self-checking bench for the configuration register bank.
// assumes a one-cycle read answer and no wait states on the register port.
`timescale 1ns/1ps
`default_nettype none

module swcfg_regs_tb_top
   import swcfg_pkg::*;
;
   // ----------------------------------------
   // stimulus signals and design
   // ----------------------------------------
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] periph_en = 32'h00000000;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic err;
   swcfg_weights_t weights;
   logic irq;
   swcfg_resets_t resets;
   logic [4:0] g;
   logic [4:0] d;
   logic [31:0] bit_v;
   int error_cnt = 0;
   int samples_checked = 0;

   swcfg_regs i_swcfg_regs (
      .clk_sys_in(clk_sys),
      .rst_n_in(rst_n),
      .periph_enabled_in(periph_en),
      .reg_addr_in(addr),
      .reg_wdata_in(wdata),
      .reg_write_in(wr),
      .reg_read_in(rd),
      .reg_rdata_out(rdata),
      .reg_err_out(err),
      .weights_out(weights),
      .fabric_irq_interface_out(irq),
      .resets_out(resets)
   );

   // 125 MHz clock
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [5:0] dec(input logic [4:0] f);
      dec = (f == 5'h00) ? 6'h20 : {1'b0, f};
   endfunction

   // reset holds in output order, taken from register bits
   function automatic logic [12:0] rmap(input logic [31:0] v);
      rmap = {v[26], v[25], v[19], v[18], v[17], v[16], v[15], v[9], v[5], v[3], v[2], v[1], v[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic do_reset(input logic [31:0] en);
      @(posedge clk_sys);
      periph_en <= en;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      #1;
   endtask

   // read, then see the answer and error flag fall back one cycle later
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
      check({31'h0, err}, {31'h0, exp_err});
      @(posedge clk_sys);
      #1;
      check(rdata, 32'h00000000);
      check({31'h0, err}, 32'h00000000);
   endtask

   task automatic chk_outs(input logic [5:0] eg, input logic [5:0] ef, input logic [31:0] rv);
      check({20'h0, weights}, {20'h0, eg, ef});
      check({19'h0, resets}, {19'h0, rmap(rv)});
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      do_reset(32'h00000000);
      chk_outs(6'h20, 6'h20, 32'h060f0220);
      check({31'h0, irq}, 32'h00000000);
      reg_read(8'h00, 32'h00000000, 1'b0);
      reg_read(8'h08, 32'h060f0220, 1'b0);
      // weight fields at boundary values, reserved bits set
      for (int i = 0; i < 4; i++) begin
         g = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i == 2) ? 5'h1f : 5'h10;
         d = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : (i == 2) ? 5'h01 : 5'h0f;
         reg_write(8'h00, 32'hffff83e0 | {17'h0, g, 10'h000} | {27'h0, d});
         check({20'h0, weights}, {20'h0, dec(g), dec(d)});
         reg_read(8'h00, {17'h0, g, 5'h00, d}, 1'b0);
      end
      // interrupt bit follows the register
      reg_write(8'h04, 32'hffffffff);
      check({31'h0, irq}, 32'h00000001);
      reg_read(8'h04, 32'h00000001, 1'b0);
      reg_write(8'h04, 32'hfffffffe);
      check({31'h0, irq}, 32'h00000000);
      // walking one across the reset register
      for (int b = 0; b < 32; b++) begin
         bit_v = 32'h00000001 << b;
         reg_write(8'h08, bit_v);
         check({19'h0, resets}, {19'h0, rmap(bit_v)});
         reg_read(8'h08, bit_v & 32'h060f822f, 1'b0);
      end
      // unmapped address: ignored, flagged
      reg_write(8'h0c, 32'hffffffff);
      check({31'h0, err}, 32'h00000001);
      reg_read(8'h0c, 32'h00000000, 1'b1);
      reg_read(8'h08, 32'h80000000 & 32'h060f822f, 1'b0);
      // mid-run reset with configured blocks
      do_reset(32'h00000220);
      chk_outs(6'h20, 6'h20, 32'h060f0000);
      reg_read(8'h08, 32'h060f0000, 1'b0);
      do_reset(32'hffffffff);
      reg_read(8'h08, 32'h00000000, 1'b0);
      wrap_up();
   end

   // watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      wrap_up();
   end
endmodule // swcfg_regs_tb_top

`default_nettype wire
